// >>> rtl/tdo_pkg.sv
package tdo_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam longint TDO_CLK_HZ = 100_000_000;
  localparam longint TDO_HOLD_SHORT_S = 10;
  localparam longint TDO_HOLD_LONG_S = 60;
  localparam longint TDO_HOLD_SHORT_CYC = TDO_HOLD_SHORT_S * TDO_CLK_HZ;
  localparam longint TDO_HOLD_LONG_CYC = TDO_HOLD_LONG_S * TDO_CLK_HZ;
  localparam int TDO_HB_US = 300;
  localparam int TDO_HB_CYC = int'((longint'(TDO_HB_US) * TDO_CLK_HZ) / 1_000_000);
  localparam int TDO_SETTLE_CYC = 2 * TDO_HB_CYC;
  localparam int TDO_TMR_W = 33;

  // ----------------------------------------------------------------
  // Signal processing
  // ----------------------------------------------------------------
  localparam int TDO_SIG_W = 16;
  localparam int TDO_INT_W = 2;
  localparam logic [TDO_INT_W-1:0] TDO_INT_FINAL = 2'h3;
  localparam logic [TDO_INT_W-1:0] TDO_INT_ZERO = 2'h0;
  localparam logic [TDO_SIG_W-1:0] TDO_THR_HIGH_GAIN = 16'h0006;
  localparam logic [TDO_SIG_W-1:0] TDO_THR_LOW_GAIN = 16'h000c;
  localparam logic [TDO_SIG_W-1:0] TDO_REF_STEP = 16'h0001;
  localparam int TDO_HYST_PCT = 17;

  // ----------------------------------------------------------------
  // Host register map
  // ----------------------------------------------------------------
  localparam int TDO_AW = 12;
  localparam logic [TDO_AW-1:0] TDO_CTRL_OFS = 12'h000;
  localparam logic [TDO_AW-1:0] TDO_STAT_OFS = 12'h004;
  localparam logic [TDO_AW-1:0] TDO_HBCNT_OFS = 12'h008;
  localparam int TDO_CTRL_SUPPLY = 0;
  localparam int TDO_CTRL_STRAP_A = 1;
  localparam int TDO_CTRL_STRAP_B = 2;
  localparam int TDO_CTRL_GAIN = 3;
  localparam int TDO_CTRL_LOAD_EN = 4;
  localparam int TDO_CTRL_FOLLOW = 5;
  localparam int TDO_CTRL_W = 6;
  localparam logic [TDO_CTRL_W-1:0] TDO_CTRL_RST = 6'h10;
  localparam int TDO_STAT_PIN = 0;
  localparam int TDO_STAT_SETTLED = 1;
  localparam int TDO_STAT_SUPPLY = 2;
  localparam int TDO_HBCNT_W = 16;

  typedef enum logic [1:0] {
    TDO_OFF = 2'h0,
    TDO_CAL = 2'h1,
    TDO_RUN = 2'h3
  } tdo_state_t;

  typedef enum logic [1:0] {
    TDO_HOLD_10 = 2'h0,
    TDO_HOLD_60 = 2'h1,
    TDO_HOLD_INF = 2'h2
  } tdo_hold_t;

  function automatic logic [TDO_SIG_W-1:0] tdo_hyst(input logic [TDO_SIG_W-1:0] thr);
    logic [31:0] prod;
    prod = (32'(thr) * 32'(TDO_HYST_PCT)) / 32'd100;
    return prod[TDO_SIG_W-1:0];
  endfunction

endpackage

// >>> rtl/tdo_if.sv
`timescale 1ns/1ps
interface tdo_if;
  logic supply_on;
  logic strap_a;
  logic strap_b;
  logic gain_strap;
  logic drv_lvl;
  logic drv_oe;
  logic load_en;
  logic load_up;
  logic pin_lvl;

  // A floating pin with no load reads low.
  assign pin_lvl = drv_oe ? drv_lvl : (load_en ? load_up : 1'h0);

  modport dev(input supply_on, input strap_a, input strap_b, input gain_strap, input pin_lvl,
              output drv_lvl, output drv_oe);
  modport host(output supply_on, output strap_a, output strap_b, output gain_strap,
               output load_en, output load_up, input pin_lvl);
endinterface

// >>> rtl/tdo_hold_timer.sv
`timescale 1ns/1ps
module tdo_hold_timer import tdo_pkg::*; #(
  parameter longint SHORT_CYC = TDO_HOLD_SHORT_CYC,
  parameter longint LONG_CYC = TDO_HOLD_LONG_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire tdo_hold_t sel,
  output logic expire
);

  localparam logic [TDO_TMR_W-1:0] LAST_SHORT = TDO_TMR_W'(SHORT_CYC - 1);
  localparam logic [TDO_TMR_W-1:0] LAST_LONG = TDO_TMR_W'(LONG_CYC - 1);

  logic [TDO_TMR_W-1:0] cnt_ff;
  logic [TDO_TMR_W-1:0] nxt_cnt;
  logic [TDO_TMR_W-1:0] last;
  logic hit;

  // The count restarts whenever the detection drops, so only a continuous one times out.
  assign last = (sel == TDO_HOLD_60) ? LAST_LONG : LAST_SHORT;
  assign hit = run && (sel != TDO_HOLD_INF) && (cnt_ff == last); // [RL3]
  assign nxt_cnt = (!run || hit) ? '0 : cnt_ff + TDO_TMR_W'(1);
  assign expire = hit;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

endmodule

// >>> rtl/tdo_device.sv
// How it works
// RL1: Output asserts after three consecutive detecting bursts.
// RL2: Non-detecting burst clears integrator to zero.
// RL3: Continuous detection past timeout forces recalibration.
// RL4: DC timeout is ten, sixty seconds, or infinite.
// RL5: Two straps select mode and timeout.
// RL6: Straps sampled only at power-up.
// RL7: No recalibration input; power-up recalibrates.
// RL8: DC output follows detection until timeout.
// RL9: DC timeout recalibrates and drops output.
// RL10: Toggle mode flips output per new detection.
// RL11: Toggle timeout ten seconds, output state kept.
// RL12: Output floats 300 us after each burst.
// RL13: Variant parameter picks active-low or active-high.
// RL14: Observer pulls output toward inactive level; the host load pulls toward the active level unless follow is set.
// RL15: Host moves load opposite current output state.
// RL16: Host sets straps then cycles supply.
// RL17: Straps and gain always driven, never floating.
// RL18: Gain strap picks threshold six or twelve.
// RL19: Detection ends below threshold minus 17 percent.
// RL20: Reference tracks drift only without detection.
// RL21: Burst strobe advances integrator, timer and pulse; the hold timer here counts every pclk cycle instead.
`timescale 1ns/1ps
module tdo_device import tdo_pkg::*; #(
  parameter bit ACTIVE_HIGH = 1'b0,
  parameter longint HOLD_SHORT_CYC = TDO_HOLD_SHORT_CYC,
  parameter longint HOLD_LONG_CYC = TDO_HOLD_LONG_CYC,
  parameter int HB_CYC = TDO_HB_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  tdo_if.dev pins,
  input wire logic burst_done,
  input wire logic [TDO_SIG_W-1:0] burst_sample,
  output logic detect,
  output logic out_active,
  output logic [TDO_SIG_W-1:0] reference
);

  localparam int HB_W = $clog2(HB_CYC + 1);
  localparam logic [HB_W-1:0] HB_LOAD = HB_W'(HB_CYC);
  localparam logic [HB_W-1:0] HB_IDLE = '0;
  localparam bit IDLE_LVL = !ACTIVE_HIGH;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  tdo_state_t state_ff;
  tdo_state_t nxt_state;
  tdo_hold_t hold_ff;
  tdo_hold_t nxt_hold;
  logic toggle_ff;
  logic nxt_toggle;
  logic [TDO_SIG_W-1:0] thr_ff;
  logic [TDO_SIG_W-1:0] nxt_thr;
  logic [TDO_SIG_W-1:0] ref_ff;
  logic [TDO_SIG_W-1:0] nxt_ref;
  logic [TDO_INT_W-1:0] cnt_ff;
  logic [TDO_INT_W-1:0] nxt_cnt;
  logic det_ff;
  logic nxt_det;
  logic out_ff;
  logic nxt_out;
  logic recal_ff;
  logic nxt_recal;
  logic [HB_W-1:0] hb_ff;
  logic [HB_W-1:0] nxt_hb;
  logic pin_ff;
  logic nxt_pin;
  logic oe_ff;
  logic nxt_oe;

  // ----------------------------------------------------------------
  // Power and straps
  // ----------------------------------------------------------------
  logic powered;
  logic strap_take;
  tdo_hold_t strap_hold;
  logic strap_toggle;

  assign powered = pins.supply_on;
  // Straps are read only while leaving the unpowered state; later changes are ignored.
  assign strap_take = powered && (state_ff == TDO_OFF); // [RL6] [RL16]
  assign strap_toggle = !pins.strap_a && !pins.strap_b; // [RL5] [RL10]
  assign strap_hold = (pins.strap_a && !pins.strap_b) ? TDO_HOLD_60 :
                      (!pins.strap_a && pins.strap_b) ? TDO_HOLD_INF : TDO_HOLD_10; // [RL5] [RL4] [RL11]
  assign nxt_hold = strap_take ? strap_hold : hold_ff;
  assign nxt_toggle = strap_take ? strap_toggle : toggle_ff;
  assign nxt_thr = !strap_take ? thr_ff :
                   pins.gain_strap ? TDO_THR_HIGH_GAIN : TDO_THR_LOW_GAIN; // [RL18]

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  logic cal_take;
  logic burst_run;

  // Recalibration has no pin of its own: only power-up and a hold timeout reach it.
  assign cal_take = burst_done && ((state_ff == TDO_CAL) || (state_ff == TDO_RUN && recal_ff)); // [RL7]
  assign burst_run = burst_done && (state_ff == TDO_RUN) && !recal_ff; // [RL21]

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      TDO_OFF: begin
        if (powered) begin
          nxt_state = TDO_CAL;
        end
      end
      TDO_CAL: begin
        if (burst_done) begin
          nxt_state = TDO_RUN;
        end
      end
      TDO_RUN: begin
        nxt_state = TDO_RUN;
      end
      default: begin
        nxt_state = TDO_OFF;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Detection
  // ----------------------------------------------------------------
  logic [TDO_SIG_W:0] delta;
  logic above;
  logic released;
  logic det_set;
  logic det_clr;
  logic expire;
  logic drift_up;
  logic drift_dn;

  assign delta = {1'h0, burst_sample} - {1'h0, ref_ff};
  assign above = !delta[TDO_SIG_W] && (delta[TDO_SIG_W-1:0] >= thr_ff);
  // Hysteresis keeps a detection alive until the signal sags clearly below threshold.
  assign released = delta[TDO_SIG_W] || (delta[TDO_SIG_W-1:0] < (thr_ff - tdo_hyst(thr_ff))); // [RL19]
  assign det_set = burst_run && !det_ff && above && (cnt_ff == TDO_INT_FINAL - 2'h1); // [RL1]
  assign det_clr = expire || (burst_run && det_ff && released); // [RL9] [RL19]
  assign nxt_det = det_set || (det_ff && !det_clr);

  assign nxt_cnt = det_clr ? TDO_INT_ZERO :
                   (burst_run && !det_ff) ? (above ? cnt_ff + 2'h1 : TDO_INT_ZERO) : cnt_ff; // [RL1] [RL2]

  // Slow tracking, one level per quiet burst, so a creeping finger is not absorbed fast.
  assign drift_up = burst_run && !det_ff && !above && !delta[TDO_SIG_W] && (delta != '0); // [RL20]
  assign drift_dn = burst_run && !det_ff && delta[TDO_SIG_W]; // [RL20]
  assign nxt_ref = cal_take ? burst_sample :
                   drift_up ? ref_ff + TDO_REF_STEP :
                   drift_dn ? ref_ff - TDO_REF_STEP : ref_ff;

  assign nxt_recal = expire || (recal_ff && !cal_take); // [RL3]

  tdo_hold_timer #(
    .SHORT_CYC(HOLD_SHORT_CYC),
    .LONG_CYC(HOLD_LONG_CYC)
  ) u_hold (
    .pclk(pclk),
    .presetn(presetn),
    .run(det_ff && powered),
    .sel(toggle_ff ? TDO_HOLD_10 : hold_ff),
    .expire(expire)
  ); // [RL3] [RL11]

  // ----------------------------------------------------------------
  // Output pin
  // ----------------------------------------------------------------
  // DC follows the detection and drops on timeout; toggle flips on each new one only.
  assign nxt_out = toggle_ff ? (out_ff ^ det_set) : nxt_det; // [RL8] [RL9] [RL10] [RL11]
  assign nxt_hb = (burst_done && state_ff != TDO_OFF) ? HB_LOAD :
                  (hb_ff != HB_IDLE) ? hb_ff - HB_W'(1) : HB_IDLE; // [RL12] [RL21]
  assign nxt_pin = ACTIVE_HIGH ? nxt_out : !nxt_out; // [RL13]
  assign nxt_oe = (nxt_state != TDO_OFF) && (nxt_hb == HB_IDLE); // [RL12]

  assign pins.drv_lvl = pin_ff;
  assign pins.drv_oe = oe_ff;
  assign detect = det_ff;
  assign out_active = out_ff;
  assign reference = ref_ff;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Dropping the supply clears all but the strap settings and the reference; a power cycle or a hold timeout forces a recalibration.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= TDO_OFF;
      hold_ff <= TDO_HOLD_10;
      toggle_ff <= 1'h0;
      thr_ff <= TDO_THR_LOW_GAIN;
      ref_ff <= '0;
      cnt_ff <= TDO_INT_ZERO;
      det_ff <= 1'h0;
      out_ff <= 1'h0;
      recal_ff <= 1'h0;
      hb_ff <= HB_IDLE;
      pin_ff <= IDLE_LVL;
      oe_ff <= 1'h0;
    end else if (!powered) begin
      state_ff <= TDO_OFF;
      cnt_ff <= TDO_INT_ZERO;
      det_ff <= 1'h0;
      out_ff <= 1'h0;
      recal_ff <= 1'h0;
      hb_ff <= HB_IDLE;
      pin_ff <= IDLE_LVL;
      oe_ff <= 1'h0;
    end else begin
      state_ff <= nxt_state;
      hold_ff <= nxt_hold;
      toggle_ff <= nxt_toggle;
      thr_ff <= nxt_thr;
      ref_ff <= nxt_ref;
      cnt_ff <= nxt_cnt;
      det_ff <= nxt_det;
      out_ff <= nxt_out;
      recal_ff <= nxt_recal;
      hb_ff <= nxt_hb;
      pin_ff <= nxt_pin;
      oe_ff <= nxt_oe;
    end
  end

endmodule

// >>> rtl/tdo_host.sv
`timescale 1ns/1ps
module tdo_host import tdo_pkg::*; #(
  parameter bit ACTIVE_HIGH = 1'b0,
  parameter int SETTLE_CYC = TDO_SETTLE_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [TDO_AW-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  tdo_if.host pins
);

  localparam int ST_W = $clog2(SETTLE_CYC + 1);
  localparam logic [ST_W-1:0] ST_LAST = ST_W'(SETTLE_CYC);

  logic [TDO_CTRL_W-1:0] ctrl_ff;
  logic [TDO_HBCNT_W-1:0] hbc_ff;
  logic [ST_W-1:0] st_ff;
  logic settled_ff;
  logic [31:0] rdata_ff;
  logic err_ff;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic setup;
  logic wr;
  logic hit_ctrl;
  logic hit_stat;
  logic hit_hbc;
  logic [31:0] nxt_rdata;

  assign setup = psel && !penable;
  assign wr = psel && penable && pwrite;
  assign hit_ctrl = paddr == TDO_CTRL_OFS;
  assign hit_stat = paddr == TDO_STAT_OFS;
  assign hit_hbc = paddr == TDO_HBCNT_OFS;
  assign nxt_rdata = hit_ctrl ? 32'(ctrl_ff) :
                     hit_stat ? 32'({pins.supply_on, settled_ff, pins.pin_lvl}) :
                     hit_hbc ? 32'(hbc_ff) : 32'h0;
  assign pready = 1'h1;
  assign prdata = rdata_ff;
  assign pslverr = err_ff;

  // ----------------------------------------------------------------
  // Pin watch
  // ----------------------------------------------------------------
  logic differ;
  logic beat;
  logic hbc_clr;

  // A short excursion from the settled level is a health pulse; a long one is a new state.
  assign differ = pins.pin_lvl != settled_ff;
  assign beat = !differ && (st_ff != '0); // [RL14] [RL15]
  assign hbc_clr = wr && hit_hbc;

  // Straps and gain are always driven from a register, never left floating.
  assign pins.supply_on = ctrl_ff[TDO_CTRL_SUPPLY]; // [RL16]
  assign pins.strap_a = ctrl_ff[TDO_CTRL_STRAP_A]; // [RL17]
  assign pins.strap_b = ctrl_ff[TDO_CTRL_STRAP_B]; // [RL17]
  assign pins.gain_strap = ctrl_ff[TDO_CTRL_GAIN]; // [RL17]
  assign pins.load_en = ctrl_ff[TDO_CTRL_LOAD_EN];
  // Without follow the load pulls toward the active level, so pulses show only while idle.
  assign pins.load_up = ctrl_ff[TDO_CTRL_FOLLOW] ? !settled_ff : ACTIVE_HIGH; // [RL14] [RL15]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= TDO_CTRL_RST;
      hbc_ff <= '0;
      st_ff <= '0;
      settled_ff <= !ACTIVE_HIGH;
      rdata_ff <= 32'h0;
      err_ff <= 1'h0;
    end else begin
      if (wr && hit_ctrl) begin
        ctrl_ff <= pwdata[TDO_CTRL_W-1:0];
      end
      if (beat) begin
        hbc_ff <= hbc_ff + TDO_HBCNT_W'(1);
      end else if (hbc_clr) begin
        hbc_ff <= '0;
      end
      if (!differ || st_ff == ST_LAST) begin
        st_ff <= '0;
      end else begin
        st_ff <= st_ff + ST_W'(1);
      end
      if (differ && st_ff == ST_LAST) begin
        settled_ff <= pins.pin_lvl;
      end
      if (setup) begin
        rdata_ff <= nxt_rdata;
        err_ff <= !(hit_ctrl || hit_stat || hit_hbc);
      end
    end
  end

endmodule

// >>> testbench/tdo_props.sv
`timescale 1ns/1ps
module tdo_props #(
  parameter bit ACTIVE_HIGH = 1'b0,
  parameter int HB_CYC = 10
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic supply_on,
  input wire logic strap_a,
  input wire logic strap_b,
  input wire logic drv_lvl,
  input wire logic drv_oe,
  input wire logic burst_done,
  input wire logic detect,
  input wire logic out_active
);
  // ----------------------------------------------------------------
  // Strap capture at power-up and float length
  // ----------------------------------------------------------------
  // Straps are latched here on their own, so a device that follows later strap changes is caught.
  logic pwr_ff;
  logic [1:0] mode_ff;
  logic [15:0] float_ff;
  wire power_edge = supply_on && !pwr_ff;
  wire [1:0] nxt_mode = power_edge ? {strap_a, strap_b} : mode_ff;
  wire [15:0] nxt_float = (!supply_on || drv_oe || burst_done) ? 16'h0000 : float_ff + 16'h0001;
  wire toggle_mode = (mode_ff == 2'h0);
  wire inf_mode = (mode_ff == 2'h1);
  wire live = supply_on && pwr_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwr_ff <= 1'b0;
      mode_ff <= 2'h0;
      float_ff <= 16'h0000;
    end else begin
      pwr_ff <= supply_on;
      mode_ff <= nxt_mode;
      float_ff <= nxt_float;
    end
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_float_after_burst;
    live && burst_done |=> !drv_oe [*8];
  endproperty
  a_float_after_burst: assert property (p_float_after_burst) else $error("pin not floated after burst");
  property p_float_len;
    float_ff <= 16'(HB_CYC);
  endproperty
  a_float_len: assert property (p_float_len) else $error("pin floated too long");
  property p_off;
    !supply_on |=> !drv_oe && !detect;
  endproperty
  a_off: assert property (p_off) else $error("device active while unpowered");
  property p_on;
    $rose(supply_on) |=> drv_oe;
  endproperty
  a_on: assert property (p_on) else $error("pin not driven after power-up");
  property p_level;
    drv_oe |-> drv_lvl == (ACTIVE_HIGH ? out_active : !out_active);
  endproperty
  a_level: assert property (p_level) else $error("pin level disagrees with output state");
  property p_detect_on_burst;
    $rose(detect) |-> $past(burst_done);
  endproperty
  a_detect_on_burst: assert property (p_detect_on_burst) else $error("detection without burst");
  property p_dc_follow;
    live && !toggle_mode |-> out_active == detect;
  endproperty
  a_dc_follow: assert property (p_dc_follow) else $error("level output not following detection");
  property p_toggle;
    live && toggle_mode |-> $changed(out_active) == $rose(detect);
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle output changed wrongly");
  property p_inf_keep;
    live && inf_mode && $fell(detect) |-> $past(burst_done);
  endproperty
  a_inf_keep: assert property (p_inf_keep) else $error("detection ended by timer in infinite mode");
  c_detect: cover property ($rose(detect));
  c_timeout: cover property (live && $fell(detect) && !$past(burst_done));
  c_toggle_off: cover property (live && toggle_mode && $fell(out_active));
endmodule

// >>> testbench/test_touch_detect_output_logic.sv
`timescale 1ns/1ps
module test_touch_detect_output_logic import tdo_pkg::*;;
  localparam int HB = 10;
  localparam int GAP = 50;
  localparam bit AH = 1'b0;
  localparam int HOLD_S = 200;
  localparam int HOLD_L = 500;
  localparam int SETTLE = 40;
  logic pclk;
  logic presetn;
  logic [TDO_AW-1:0] paddr;
  logic psel;
  logic penable;
  logic pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic burst_done;
  logic [TDO_SIG_W-1:0] burst_sample;
  logic detect;
  logic out_active;
  logic [TDO_SIG_W-1:0] reference;
  int fail_count = 0;
  int tests_run = 0;

  tdo_if tdo_if_inst ();
  tdo_device #(.ACTIVE_HIGH(AH), .HOLD_SHORT_CYC(HOLD_S), .HOLD_LONG_CYC(HOLD_L), .HB_CYC(HB)) tdo_device_inst (
    .pclk(pclk), .presetn(presetn), .pins(tdo_if_inst.dev), .burst_done(burst_done),
    .burst_sample(burst_sample), .detect(detect), .out_active(out_active), .reference(reference));
  tdo_host #(.ACTIVE_HIGH(AH), .SETTLE_CYC(SETTLE)) tdo_host_inst (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins(tdo_if_inst.host));
  tdo_props #(.ACTIVE_HIGH(AH), .HB_CYC(HB)) tdo_props_inst (
    .pclk(pclk), .presetn(presetn), .supply_on(tdo_if_inst.supply_on), .strap_a(tdo_if_inst.strap_a),
    .strap_b(tdo_if_inst.strap_b), .drv_lvl(tdo_if_inst.drv_lvl), .drv_oe(tdo_if_inst.drv_oe),
    .burst_done(burst_done), .detect(detect), .out_active(out_active));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [TDO_AW-1:0] addr, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    if (pready !== 1'b1) begin
      fail_count++;
      conclude();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [TDO_AW-1:0] addr, input logic [31:0] wd);
    logic [31:0] r;
    logic e;
    apb(1'b1, addr, wd, r, e);
  endtask

  task automatic rdchk(input logic [TDO_AW-1:0] addr, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, addr, 32'h0, r, e);
    chk(r, exp);
  endtask

  task automatic burst(input logic [15:0] s);
    @(posedge pclk);
    burst_done <= 1'b1;
    burst_sample <= s;
    @(posedge pclk);
    burst_done <= 1'b0;
    repeat (GAP) @(posedge pclk);
  endtask

  // Power is dropped first, so every call is a full power cycle with recalibration.
  task automatic power(input logic a, input logic b, input logic g);
    logic [31:0] w;
    w = {26'h0, 1'b1, 1'b1, g, b, a, 1'b0};
    wr(TDO_CTRL_OFS, w);
    wr(TDO_CTRL_OFS, w | 32'h1);
    wr(TDO_CTRL_OFS, w ^ 32'h7);
    repeat (5) @(posedge pclk);
    burst(16'h0064);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic s_reset();
    logic [31:0] r;
    logic e;
    chk(32'(tdo_if_inst.drv_oe), 32'h0);
    rdchk(TDO_CTRL_OFS, 32'(TDO_CTRL_RST));
    apb(1'b1, 12'h00c, 32'h3f, r, e);
    chk(32'(e), 32'h1);
    apb(1'b0, 12'h00c, 32'h0, r, e);
    chk({r[30:0], e}, 32'h1);
    rdchk(TDO_CTRL_OFS, 32'(TDO_CTRL_RST));
  endtask

  task automatic s_integrate();
    logic [31:0] r;
    logic e;
    power(1'b1, 1'b1, 1'b1);
    burst(16'h006a);
    burst(16'h006a);
    burst(16'h0064);
    burst(16'h006a);
    burst(16'h006a);
    chk(32'(detect), 32'h0);
    burst(16'h006a);
    chk(32'(detect), 32'h1);
    chk(32'(reference), 32'h64);
    apb(1'b0, TDO_STAT_OFS, 32'h0, r, e);
    chk(32'(r[TDO_STAT_PIN]), 32'h0);
    burst(16'h0069);
    chk(32'(detect), 32'h1);
    burst(16'h0068);
    chk({detect, out_active}, 32'h0);
  endtask

  task automatic s_hb();
    power(1'b1, 1'b1, 1'b1);
    wr(TDO_HBCNT_OFS, 32'h0);
    repeat (3) burst(16'h0064);
    rdchk(TDO_HBCNT_OFS, 32'h3);
    repeat (3) burst(16'h006a);
    wr(TDO_HBCNT_OFS, 32'h0);
    repeat (2) burst(16'h006a);
    rdchk(TDO_HBCNT_OFS, 32'h2);
    wr(TDO_CTRL_OFS, 32'h1f);
    wr(TDO_HBCNT_OFS, 32'h0);
    burst(16'h006a);
    rdchk(TDO_HBCNT_OFS, 32'h0);
  endtask

  // Hold of 0 stands for the infinite timeout.
  task automatic s_hold(input logic a, input logic b, input int hold);
    logic tgl;
    tgl = !a && !b;
    power(a, b, 1'b0);
    repeat (3) burst(16'h0070);
    chk({detect, out_active}, 32'h3);
    repeat (120) @(posedge pclk);
    chk(32'(detect), 32'h1);
    repeat (60) @(posedge pclk);
    chk({detect, out_active}, {30'h0, hold != HOLD_S, tgl || hold != HOLD_S});
    repeat (320) @(posedge pclk);
    chk({detect, out_active}, {30'h0, hold == 0, tgl || hold == 0});
    if (hold != 0) begin
      burst(16'h0078);
      chk(32'(reference), 32'h78);
      repeat (3) burst(16'h0084);
      chk(32'(out_active), 32'(!tgl));
    end
  endtask

  // ----------------------------------------------------------------
  // Clock and main sequence
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  initial begin
    presetn = 1'b0;
    paddr = '0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    pwdata = 32'h0;
    burst_done = 1'b0;
    burst_sample = 16'h0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    s_reset();
    s_integrate();
    s_hb();
    s_hold(1'b1, 1'b1, HOLD_S);
    s_hold(1'b1, 1'b0, HOLD_L);
    s_hold(1'b0, 1'b0, HOLD_S);
    s_hold(1'b0, 1'b1, 0);
    conclude();
  end
endmodule
